/* logic/smce_defines.svh */
// register offsets, status codes, opcodes and cycle counts of the executor
// assumes inclusion by the package and the executor only
`ifndef SMCE_DEFINES_SVH
`define SMCE_DEFINES_SVH

// ****************************************************************
// apb register offsets
// ****************************************************************
`define SMCE_OFS_STACK_PUSH 8'h00
`define SMCE_OFS_STACK_POP 8'h04
`define SMCE_OFS_COMMAND 8'h08
`define SMCE_OFS_STATUS 8'h0c
`define SMCE_STAT_BUSY_BIT 8
`define SMCE_STAT_SVC_BIT 9

// ****************************************************************
// error field codes
// ****************************************************************
`define SMCE_ERR_NONE 4'h0
`define SMCE_ERR_BAD_ARG 4'h4
`define SMCE_ERR_EXP_RANGE 4'hc
`define SMCE_ERR_OVERFLOW 4'h8
`define SMCE_ERR_UNDERFLOW 4'h2

// ****************************************************************
// opcode low seven bits, bit 7 is the service request bit
// ****************************************************************
`define SMCE_OP_FLOAT_TO_SHORT_INT 7'h1f
`define SMCE_OP_LONG_INT_TO_FLOAT 7'h1c
`define SMCE_OP_SHORT_INT_TO_FLOAT 7'h1d
`define SMCE_OP_FLOAT_MULTIPLY 7'h12
`define SMCE_OP_FLOAT_SUBTRACT 7'h11
`define SMCE_OP_LOG_COMMON 7'h08
`define SMCE_OP_LOG_NATURAL 7'h09
`define SMCE_OP_IDLE_COMMAND 7'h00
`define SMCE_OP_POP_LONG_A 7'h38
`define SMCE_OP_POP_LONG_B 7'h18
`define SMCE_OP_POP_SHORT 7'h78
`define SMCE_OP_DUP_LONG_A 7'h37
`define SMCE_OP_DUP_LONG_B 7'h17
`define SMCE_OP_DUP_SHORT 7'h77
`define SMCE_OP_PUSH_PI_CONST 7'h1a
`define SMCE_OP_FLOAT_POWER 7'h0b

// ****************************************************************
// execution times in clock cycles
// ****************************************************************
`define SMCE_CYC_FLOAT_TO_SHORT 14'd90
`define SMCE_CYC_LONG_TO_FLOAT 14'd56
`define SMCE_CYC_SHORT_TO_FLOAT 14'd62
`define SMCE_CYC_MULTIPLY 14'd146
`define SMCE_CYC_SUBTRACT 14'd70
`define SMCE_CYC_SUBTRACT_ZERO 14'd26
`define SMCE_CYC_LOG_BAD_ARG 14'd20
`define SMCE_CYC_IDLE 14'd4
`define SMCE_CYC_POP_LONG 14'd12
`define SMCE_CYC_POP_SHORT 14'd10
`define SMCE_CYC_DUP_LONG 14'd20
`define SMCE_CYC_DUP_SHORT 14'd16
`define SMCE_CYC_PUSH_PI 14'd16
`define SMCE_CYC_LOG_COMMON 4474
`define SMCE_CYC_LOG_NATURAL 4298
`define SMCE_CYC_POWER 8290

// ****************************************************************
// constants
// ****************************************************************
`define SMCE_PI_WORD 32'h02c90fdb
`define SMCE_Q16_LN2 32'h0000b172
`define SMCE_Q16_LOG10_2 32'h00004d10
`define SMCE_Q16_EXP_LIMIT 32'h00200000
`define SMCE_STACK_DEPTH 8

`endif

/* logic/smce_executor.sv */
// stack math command executor with an apb register port
// assumes an apb master on clk_i and ce_i high for normal running
//
// Summary of operation
// - float to short int: result on top, stack moves up one entry.
// - short conversion overflow beyond 15 bits sets overflow, keeps A.
// - float to short int lasts 90 cycles, updates sign zero overflow.
// - long int to float converts top in place, 56 cycles.
// - short int to float: low half replaces A, high half on top.
// - float multiply replaces B with product, stack moves up.
// - exponent overflow or underflow flagged, exponent wraps by 128.
// - float subtract B minus A, 70 cycles or 26 when A zero.
// - common log replaces top, 4474 cycles, 20 when not positive.
// - common log of non positive value reports error 0100.
// - natural log replaces top, non positive gives 0100 in 20 cycles.
// - idle command keeps stack, takes 4 cycles, clears status byte.
// - opcode bit 7 sets the service request line on completion.
// - long pops rotate the 32-bit stack up, 12 cycles.
// - short pop rotates the 16-bit stack up, 10 cycles.
// - long dups push down copying top, 20 cycles.
// - pi push loads pi on top, 16 cycles.
// - short dup pushes 16-bit stack down copying top, 16 cycles.
// - power raises B to A, replaces B, stack moves up.
// - power: bad base gives 0100, exponent product over 32 gives 1100.
// - stack is eight 16-bit entries, long operands take two.
`timescale 1ns/10ps
`default_nettype none
`include "smce_defines.svh"
module smce_executor
  import smce_pkg::*;
#(
  parameter int LOG_CYC = `SMCE_CYC_LOG_COMMON,
  parameter int LN_CYC = `SMCE_CYC_LOG_NATURAL,
  parameter int PWR_CYC = `SMCE_CYC_POWER
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  output logic busy_o,
  output logic svc_req_o
);

  // ****************************************************************
  // float helpers
  // ****************************************************************
  function automatic smce_flt_t norm(input logic signed [49:0] v,
                                     input logic signed [9:0] lsb);
    smce_flt_t r;
    logic [49:0] m;
    logic [49:0] t;
    int p;
    m = v[49] ? 50'(-v) : 50'(v);
    p = -1;
    for (int i = 0; i < 50; i++)
    begin
      if (m[i])
        p = i;
    end
    t = (p >= 23) ? (m >> (p - 23)) : (m << (23 - p));
    r.sign = v[49];
    r.zero = (p < 0);
    r.mant = t[23:0];
    r.exp = 10'(p + 1) + lsb;
    return r;
  endfunction : norm

  function automatic smce_pack_t pack(input smce_flt_t f);
    smce_pack_t r;
    r.ovf = !f.zero && (f.exp > 10'sd63);
    r.unf = !f.zero && (f.exp < -10'sd64);
    r.word = f.zero ? 32'h0 : {f.sign, f.exp[6:0], f.mant};
    return r;
  endfunction : pack

  function automatic smce_flt_t unpack(input logic [31:0] w);
    smce_flt_t r;
    r.sign = w[31];
    r.zero = !w[23];
    r.exp = r.zero ? -10'sd256 : {{3{w[30]}}, w[30:24]};
    r.mant = w[23:0];
    return r;
  endfunction : unpack

  function automatic logic signed [48:0] to_fixed(input smce_flt_t f,
                                                  input int frac);
    logic signed [9:0] sh;
    logic [48:0] mag;
    sh = f.exp - 10'sd24 + 10'(frac);
    if (f.zero)
      mag = '0;
    else if (sh >= 0)
      mag = {25'h0, f.mant} << ((sh > 10'sd24) ? 24 : sh);
    else
      mag = {25'h0, f.mant} >> (-sh);
    return f.sign ? -$signed(mag) : $signed(mag);
  endfunction : to_fixed

  function automatic logic signed [31:0] log2_q16(input smce_flt_t f);
    logic signed [9:0] e1;
    e1 = f.exp - 10'sd1;
    return {{6{e1[9]}}, e1, 16'h0} + {16'h0, f.mant[22:7]};
  endfunction : log2_q16

  function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
                                              input logic signed [31:0] b);
    logic signed [63:0] p;
    p = a * b;
    return p[47:16];
  endfunction : qmul

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] stack_q [`SMCE_STACK_DEPTH];
  logic [15:0] stack_d [`SMCE_STACK_DEPTH];
  smce_status_t status_q;
  smce_status_t status_d;
  smce_state_t state_q;
  logic [13:0] cnt_q;
  logic [7:0] op_q;
  logic svc_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  logic acc;
  logic wr_ok;
  logic issue;
  logic done;
  logic stack_busy;
  logic cmd_hit;
  logic fix_ovf;
  logic a_nonpos;
  logic b_nonpos;
  logic [13:0] issue_cyc;
  smce_flt_t fa;
  smce_flt_t fb;

  assign fa = unpack({stack_q[0], stack_q[1]});
  assign fb = unpack({stack_q[2], stack_q[3]});
  assign a_nonpos = fa.zero || fa.sign;
  assign b_nonpos = fb.zero || fb.sign;
  assign acc = ce_i && psel_i && penable_i && pready_q;
  assign stack_busy = (state_q == SMCE_EXEC);
  assign cmd_hit = (paddr_i == `SMCE_OFS_COMMAND);
  assign wr_ok = acc && !stack_busy && !pslverr_q;
  assign issue = wr_ok && pwrite_i && cmd_hit;
  assign done = ce_i && stack_busy && (cnt_q == 14'd0);

  // ****************************************************************
  // execution time per opcode
  // ****************************************************************
  always_comb
  begin
    case (pwdata_i[6:0])
      `SMCE_OP_FLOAT_TO_SHORT_INT: issue_cyc = `SMCE_CYC_FLOAT_TO_SHORT;
      `SMCE_OP_LONG_INT_TO_FLOAT: issue_cyc = `SMCE_CYC_LONG_TO_FLOAT;
      `SMCE_OP_SHORT_INT_TO_FLOAT: issue_cyc = `SMCE_CYC_SHORT_TO_FLOAT;
      `SMCE_OP_FLOAT_MULTIPLY: issue_cyc = `SMCE_CYC_MULTIPLY;
      `SMCE_OP_FLOAT_SUBTRACT: issue_cyc = fa.zero ? `SMCE_CYC_SUBTRACT_ZERO
                                                   : `SMCE_CYC_SUBTRACT;
      `SMCE_OP_LOG_COMMON: issue_cyc = a_nonpos ? `SMCE_CYC_LOG_BAD_ARG
                                                : 14'(LOG_CYC);
      `SMCE_OP_LOG_NATURAL: issue_cyc = a_nonpos ? `SMCE_CYC_LOG_BAD_ARG
                                                 : 14'(LN_CYC);
      `SMCE_OP_POP_LONG_A, `SMCE_OP_POP_LONG_B: issue_cyc = `SMCE_CYC_POP_LONG;
      `SMCE_OP_POP_SHORT: issue_cyc = `SMCE_CYC_POP_SHORT;
      `SMCE_OP_DUP_LONG_A, `SMCE_OP_DUP_LONG_B: issue_cyc = `SMCE_CYC_DUP_LONG;
      `SMCE_OP_DUP_SHORT: issue_cyc = `SMCE_CYC_DUP_SHORT;
      `SMCE_OP_PUSH_PI_CONST: issue_cyc = `SMCE_CYC_PUSH_PI;
      `SMCE_OP_FLOAT_POWER: issue_cyc = 14'(PWR_CYC);
      default: issue_cyc = `SMCE_CYC_IDLE;
    endcase
  end

  // ****************************************************************
  // command datapath, applied at completion
  // ****************************************************************
  always_comb
  begin
    smce_flt_t fr;
    smce_pack_t pr;
    logic signed [48:0] fx;
    logic signed [9:0] emax;
    logic signed [49:0] va;
    logic signed [49:0] vb;
    logic signed [31:0] y;
    logic signed [31:0] z;
    logic [47:0] prod;
    fr = '0;
    pr = '0;
    fx = '0;
    emax = '0;
    va = '0;
    vb = '0;
    y = '0;
    z = '0;
    prod = '0;
    fix_ovf = 1'b0;
    stack_d = stack_q;
    status_d = status_q;
    case (op_q[6:0])
      `SMCE_OP_FLOAT_TO_SHORT_INT:
      begin
        fx = to_fixed(fa, 0);
        fix_ovf = !fa.zero && (fa.exp > 10'sd15);
        status_d.err = fix_ovf ? `SMCE_ERR_OVERFLOW : `SMCE_ERR_NONE;
        if (!fix_ovf)
        begin
          stack_d[0] = fx[15:0];
          for (int i = 1; i < 7; i++)
            stack_d[i] = stack_q[i + 1];
          stack_d[7] = stack_q[0];
        end
        status_d.sign = stack_d[0][15];
        status_d.zero = (stack_d[0] == 16'h0);
      end
      `SMCE_OP_LONG_INT_TO_FLOAT, `SMCE_OP_SHORT_INT_TO_FLOAT:
      begin
        if (op_q[0])
          fr = norm({{34{stack_q[0][15]}}, stack_q[0]}, 10'sd0);
        else
          fr = norm({{18{stack_q[0][15]}}, stack_q[0], stack_q[1]}, 10'sd0);
        pr = pack(fr);
        if (op_q[0])
        begin
          stack_d[0] = pr.word[31:16];
          stack_d[1] = pr.word[15:0];
          for (int i = 2; i < 8; i++)
            stack_d[i] = stack_q[i - 1];
        end
        else
        begin
          stack_d[0] = pr.word[31:16];
          stack_d[1] = pr.word[15:0];
        end
        status_d.sign = pr.word[31];
        status_d.zero = !pr.word[23];
      end
      `SMCE_OP_FLOAT_MULTIPLY, `SMCE_OP_FLOAT_SUBTRACT,
      `SMCE_OP_FLOAT_POWER:
      begin
        if (op_q[6:0] == `SMCE_OP_FLOAT_MULTIPLY)
        begin
          prod = fa.mant * fb.mant;
          fr = norm({2'b00, prod}, fa.exp + fb.exp - 10'sd48);
          fr.sign = fa.sign ^ fb.sign;
          fr.zero = fa.zero || fb.zero;
        end
        else if (op_q[6:0] == `SMCE_OP_FLOAT_SUBTRACT)
        begin
          emax = (fa.exp > fb.exp) ? fa.exp : fb.exp;
          va = $signed({26'h0, fa.mant} >> (emax - fa.exp));
          vb = $signed({26'h0, fb.mant} >> (emax - fb.exp));
          va = fa.sign ? -va : va;
          vb = fb.sign ? -vb : vb;
          fr = norm(vb - va, emax - 10'sd24);
        end
        else
        begin
          y = qmul(fx_q16(fa), log2_q16(fb));
          z = qmul(y, `SMCE_Q16_LN2);
          fr.sign = 1'b0;
          fr.zero = 1'b0;
          fr.mant = {1'b1, y[15:0], 7'h0};
          fr.exp = y[25:16] + 10'sd1;
        end
        pr = pack(fr);
        stack_d[0] = pr.word[31:16];
        stack_d[1] = pr.word[15:0];
        for (int i = 2; i < 6; i++)
          stack_d[i] = stack_q[i + 2];
        stack_d[6] = stack_q[0];
        stack_d[7] = stack_q[1];
        status_d.err = pr.ovf ? `SMCE_ERR_OVERFLOW
                     : pr.unf ? `SMCE_ERR_UNDERFLOW : `SMCE_ERR_NONE;
        if (op_q[6:0] == `SMCE_OP_FLOAT_POWER)
        begin
          if (b_nonpos || ((z < 0 ? -z : z) > $signed(`SMCE_Q16_EXP_LIMIT))
              || (!fa.zero && fa.exp > 10'sd14))
          begin
            stack_d = stack_q;
            status_d.err = b_nonpos ? `SMCE_ERR_BAD_ARG
                                    : `SMCE_ERR_EXP_RANGE;
          end
        end
        status_d.sign = stack_d[0][15];
        status_d.zero = !stack_d[0][7];
      end
      `SMCE_OP_LOG_COMMON, `SMCE_OP_LOG_NATURAL:
      begin
        y = qmul(log2_q16(fa), op_q[0] ? `SMCE_Q16_LN2 : `SMCE_Q16_LOG10_2);
        pr = pack(norm({{18{y[31]}}, y}, -10'sd16));
        if (a_nonpos)
          status_d.err = `SMCE_ERR_BAD_ARG;
        else
        begin
          stack_d[0] = pr.word[31:16];
          stack_d[1] = pr.word[15:0];
          status_d.err = `SMCE_ERR_NONE;
        end
        status_d.sign = stack_d[0][15];
        status_d.zero = !stack_d[0][7];
      end
      `SMCE_OP_IDLE_COMMAND:
        status_d = '0;
      `SMCE_OP_POP_LONG_A, `SMCE_OP_POP_LONG_B, `SMCE_OP_POP_SHORT,
      `SMCE_OP_DUP_LONG_A, `SMCE_OP_DUP_LONG_B, `SMCE_OP_DUP_SHORT,
      `SMCE_OP_PUSH_PI_CONST:
      begin
        for (int i = 0; i < 8; i++)
        begin
          if (op_q[3] && !op_q[1])
            stack_d[i] = stack_q[(i + (op_q[6] ? 1 : 2)) % 8];
          else if (op_q[6])
            stack_d[i] = stack_q[(i == 0) ? 0 : i - 1];
          else
            stack_d[i] = stack_q[(i < 2) ? i : i - 2];
        end
        if (op_q[6:0] == `SMCE_OP_PUSH_PI_CONST)
        begin
          stack_d[0] = 16'(`SMCE_PI_WORD >> 16);
          stack_d[1] = 16'(`SMCE_PI_WORD);
        end
        status_d.sign = stack_d[0][15];
        status_d.zero = op_q[6] ? (stack_d[0] == 16'h0) : !stack_d[0][7];
      end
      default:
        status_d = status_q;
    endcase
  end

  function automatic logic signed [31:0] fx_q16(input smce_flt_t f);
    logic signed [48:0] v;
    v = to_fixed(f, 16);
    return v[31:0];
  endfunction : fx_q16

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= SMCE_IDLE;
      cnt_q <= 14'h0;
      op_q <= 8'h0;
      svc_q <= 1'b0;
    end
    else if (ce_i)
    begin
      case (state_q)
        SMCE_IDLE:
        begin
          if (issue)
          begin
            state_q <= SMCE_EXEC;
            cnt_q <= issue_cyc - 14'd1;
            op_q <= pwdata_i[7:0];
          end
        end
        default:
        begin
          if (cnt_q == 14'd0)
          begin
            state_q <= SMCE_IDLE;
            svc_q <= op_q[7];
          end
          else
            cnt_q <= cnt_q - 14'd1;
        end
      endcase
    end
  end

  // ****************************************************************
  // stack and status
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < 8; i++)
        stack_q[i] <= 16'h0;
      status_q <= '0;
    end
    else if (done)
    begin
      stack_q <= stack_d;
      status_q <= status_d;
    end
    else if (wr_ok && pwrite_i && paddr_i == `SMCE_OFS_STACK_PUSH)
    begin
      stack_q[0] <= pwdata_i[15:0];
      for (int i = 1; i < 8; i++)
        stack_q[i] <= stack_q[i - 1];
    end
    else if (wr_ok && !pwrite_i && paddr_i == `SMCE_OFS_STACK_POP)
    begin
      for (int i = 0; i < 8; i++)
        stack_q[i] <= stack_q[(i + 1) % 8];
    end
  end

  // ****************************************************************
  // apb slave, one wait state
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else if (ce_i)
    begin
      pready_q <= psel_i && penable_i && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      if (psel_i && penable_i && !pready_q)
      begin
        if (paddr_i == `SMCE_OFS_STATUS)
          prdata_q <= {22'h0, svc_q, stack_busy, status_q};
        else if (paddr_i == `SMCE_OFS_COMMAND)
        begin
          pslverr_q <= stack_busy && pwrite_i;
          prdata_q <= {24'h0, op_q};
        end
        else if (paddr_i == `SMCE_OFS_STACK_PUSH ||
                 paddr_i == `SMCE_OFS_STACK_POP)
        begin
          pslverr_q <= stack_busy;
          prdata_q <= {16'h0, stack_q[0]};
        end
        else
          pslverr_q <= 1'b1;
      end
    end
  end

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;
  assign busy_o = stack_busy;
  assign svc_req_o = svc_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_idle_clears_status: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[6:0] == `SMCE_OP_IDLE_COMMAND |=> status_q == '0)
    else $error("idle command left status set");
  a_idle_four_cycles: assert property (@(posedge clk_i) disable iff (!rst_b_i || !ce_i)
    issue && pwdata_i[6:0] == `SMCE_OP_IDLE_COMMAND |=> stack_busy[*4] ##1 !stack_busy)
    else $error("idle command length wrong");
  a_svc_from_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done |=> svc_q == $past(op_q[7]))
    else $error("service request does not follow bit 7");
  a_short_pop_rot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[6:0] == `SMCE_OP_POP_SHORT |=>
      stack_q[7] == $past(stack_q[0]) && stack_q[0] == $past(stack_q[1]))
    else $error("short pop did not rotate");
  a_long_dup_copy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[6:0] == `SMCE_OP_DUP_LONG_A |=>
      stack_q[2] == $past(stack_q[0]) && stack_q[0] == $past(stack_q[0]))
    else $error("long dup wrong");
  a_pi_on_top: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[6:0] == `SMCE_OP_PUSH_PI_CONST |=>
      {stack_q[0], stack_q[1]} == `SMCE_PI_WORD)
    else $error("pi not on top");
  a_log_bad_arg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[6:0] == `SMCE_OP_LOG_COMMON && a_nonpos |=>
      status_q.err == `SMCE_ERR_BAD_ARG)
    else $error("log of non positive not flagged");
  a_short_fix_ovf: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[6:0] == `SMCE_OP_FLOAT_TO_SHORT_INT && fix_ovf |=>
      stack_q[0] == $past(stack_q[0]) && status_q.err == `SMCE_ERR_OVERFLOW)
    else $error("short conversion overflow wrong");
  a_long_pop_len: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    issue && pwdata_i[6:0] == `SMCE_OP_POP_LONG_A |=> cnt_q == 14'd11)
    else $error("long pop length wrong");
  a_busy_refused: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && psel_i && penable_i && !pready_q && stack_busy && pwrite_i
      && cmd_hit |=> pslverr_q)
    else $error("command accepted while busy");
  c_issue_cmd: cover property (@(posedge clk_i) disable iff (!rst_b_i) issue);
  c_done_svc: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    done && op_q[7]);
  c_refused: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    pslverr_q && pready_q);

endmodule : smce_executor
`default_nettype wire

/* logic/smce_pkg.sv */
// types shared by the stack math command executor
// assumes smce_defines.svh on the include path
`include "smce_defines.svh"
package smce_pkg;

  typedef enum logic {SMCE_IDLE, SMCE_EXEC} smce_state_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic [3:0] err;
    logic carry;
    logic spare;
  } smce_status_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic signed [9:0] exp;
    logic [23:0] mant;
  } smce_flt_t;

  typedef struct packed {
    logic [31:0] word;
    logic ovf;
    logic unf;
  } smce_pack_t;

endpackage : smce_pkg

/* tb/smce_host_model.sv */
// apb master standing in for the host processor
// assumes calls to xfer are made at or just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module smce_host_model (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [7:0] paddr_o = 8'h00,
  output logic [31:0] pwdata_o = 32'h0
);
  // one transfer, held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d;
  endtask : xfer
endmodule : smce_host_model
`default_nettype wire

/* tb/stack_math_command_executor_bench.sv */
// self-checking bench for the stack math command executor
// assumes the host model carries all register traffic
`timescale 1ns/10ps
`default_nettype none
module stack_math_command_executor_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pready, pslverr, psel, penable, pwrite, busy, svc, err;
  logic [7:0] paddr;
  logic [31:0] prdata, pwdata, rd;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  initial
  begin
    forever #10 clk = ~clk;
  end
  smce_executor #(.LOG_CYC(40), .LN_CYC(40), .PWR_CYC(40))
    smce_executor_inst (.clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .busy_o(busy),
    .svc_req_o(svc));
  smce_host_model smce_host_model_inst (.clk_i(clk), .pready_i(pready),
    .prdata_i(prdata), .pslverr_i(pslverr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    smce_host_model_inst.xfer(wr, a, d, rd, err);
  endtask : acc
  task automatic wait_idle;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_idle
  task automatic run(input logic [7:0] op, input int cyc);
    acc(1'b1, 8'h08, {24'h0, op});
    wait_idle;
    check("busy cycles", n, cyc);
    check("service request", {31'h0, svc}, {31'h0, op[7]});
  endtask : run
  task automatic stat_err(input logic [3:0] e);
    acc(1'b0, 8'h0c, 32'h0);
    check("error field", {28'h0, rd[5:2]}, {28'h0, e});
  endtask : stat_err
  task automatic pop(input logic [15:0] v);
    acc(1'b0, 8'h04, 32'h0);
    check("popped entry", {16'h0, rd[15:0]}, {16'h0, v});
  endtask : pop
  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #200us;
    num_errors++;
    stop_test;
  end
  // ********
  // tests
  // ********
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    run(8'h11, 26);
    run(8'h88, 20);
    stat_err(4'h4);
    run(8'h89, 20);
    stat_err(4'h4);
    run(8'h00, 4);
    acc(1'b0, 8'h0c, 32'h0);
    check("status", rd, 32'h0);
    run(8'h0b, 40);
    stat_err(4'h4);
    run(8'h92, 146);
    run(8'h1f, 90);
    run(8'h9c, 56);
    run(8'h1d, 62);
    run(8'hb8, 12);
    run(8'h18, 12);
    run(8'hf8, 10);
    run(8'h37, 20);
    run(8'h97, 20);
    acc(1'b1, 8'h00, 32'h1234);
    run(8'hf7, 16);
    pop(16'h1234);
    pop(16'h1234);
    acc(1'b1, 8'h00, 32'habcd);
    acc(1'b1, 8'h00, 32'h5678);
    run(8'h78, 10);
    pop(16'habcd);
    run(8'h9a, 16);
    pop(16'h02c9);
    pop(16'h0fdb);
    acc(1'b1, 8'h00, 32'h0003);
    acc(1'b1, 8'h00, 32'h0000);
    run(8'h1c, 56);
    pop(16'h02c0);
    pop(16'h0000);
    acc(1'b1, 8'h00, 32'h0000);
    acc(1'b1, 8'h00, 32'h02c0);
    run(8'h1f, 90);
    pop(16'h0003);
    acc(1'b1, 8'h00, 32'h0000);
    acc(1'b1, 8'h00, 32'h1080);
    run(8'h9f, 90);
    stat_err(4'h8);
    pop(16'h1080);
    acc(1'b1, 8'h08, 32'h12);
    acc(1'b1, 8'h08, 32'h0);
    check("refused command", {31'h0, err}, 32'h1);
    acc(1'b0, 8'h0c, 32'h0);
    check("busy bit", {31'h0, rd[8]}, 32'h1);
    wait_idle;
    acc(1'b0, 8'h10, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    stop_test;
  end
endmodule : stack_math_command_executor_bench
`default_nettype wire
